// ---- rtl/jtag_edge_pkg.sv ----
// constants shared by the probe-side jtag edge timing logic
package jtag_edge_pkg;

    // clock and launch delay timing
    localparam int CLK_PERIOD_PS   = 10000;
    localparam int LAUNCH_DELAY_NS = 8;
    localparam int LAUNCH_DELAY_RAW =
        (LAUNCH_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LAUNCH_DELAY_CYC = (LAUNCH_DELAY_RAW < 1) ? 1 : LAUNCH_DELAY_RAW;

    // divider and delay counter widths
    localparam int DIV_W_DEF = 8;
    localparam int DLY_W     = 4;

    // reset values of the edge settings, the divider and the board reset pin
    localparam logic     LAUNCH_ALT_RST = 1'b0;
    localparam logic     CAP_FALL_RST   = 1'b1;
    localparam int       HALF_RST       = 4;
    localparam logic     BOARD_RST_IDLE = 1'b1;

    // shift engine states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } shift_state_type;

endpackage

// ---- rtl/jtag_tck_gen.sv ----
// tck divider: makes tck and flags the edge it is about to produce
`timescale 1ns/1ps
`default_nettype none
module jtag_tck_gen
    import jtag_edge_pkg::*;
#(
    parameter int DIV_W = DIV_W_DEF
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             run,
    input  wire logic [DIV_W-1:0] half,
    output var  logic             tck,
    output var  logic             rise_now,
    output var  logic             fall_now
);

    typedef struct packed {
        logic             tck;
        logic [DIV_W-1:0] cnt;
    } gen_state_type;

    gen_state_type st_ff;
    gen_state_type nxt_st;
    logic          terminal;

    ////////////////////////////////////////////////////////////////////////////
    // half-period counter; edge flags are combinational so the shift engine
    // updates its pins on the very edge that moves tck when the late launch is off
    always_comb begin
        nxt_st   = st_ff;
        terminal = run && (st_ff.cnt == half - DIV_W'(1));
        if (!run) begin
            nxt_st.cnt = '0;
            nxt_st.tck = 1'b0;
        end else if (terminal) begin
            nxt_st.cnt = '0;
            nxt_st.tck = ~st_ff.tck;
        end else begin
            nxt_st.cnt = st_ff.cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tck      = st_ff.tck;
    assign rise_now = terminal && !st_ff.tck;
    assign fall_now = terminal && st_ff.tck;

endmodule
`default_nettype wire

// ---- rtl/jtag_edge_engine.sv ----
// probe-side jtag shift engine with selectable launch and capture edges
`timescale 1ns/1ps
`default_nettype none
module jtag_edge_engine
    import jtag_edge_pkg::*;
#(
    parameter int DIV_W = DIV_W_DEF
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    // user side: one bit per tck period
    input  wire logic             bit_valid,
    output var  logic             bit_ready,
    input  wire logic             bit_tms,
    input  wire logic             bit_tdo,
    output var  logic             cap_valid,
    output var  logic             cap_tdi,
    output var  logic             busy,
    // edge and period settings, taken over by cfg_load, and the board reset request
    input  wire logic             cfg_load,
    input  wire logic             launch_rise_sel,
    input  wire logic             capture_fall_sel,
    input  wire logic [DIV_W-1:0] half_period,
    input  wire logic             board_reset_req,
    // target pins
    output var  logic             tck,
    output var  logic             tms,
    output var  logic             tdo,
    input  wire logic             tdi,
    output var  logic             board_reset_n
);

    typedef struct packed {
        shift_state_type  fsm;
        logic             tms;
        logic             tdo;
        logic             pend;
        logic             pend_tms;
        logic             pend_tdo;
        logic             cfg_alt;
        logic             cfg_cap_fall;
        logic [DIV_W-1:0] cfg_half;
        logic             stg_pend;
        logic             stg_alt;
        logic             stg_cap_fall;
        logic [DIV_W-1:0] stg_half;
        logic [DLY_W-1:0] dly;
        logic             launched;
        logic             cap_valid;
        logic             cap_tdi;
        logic             board_rst_n;
        logic             bit_ready;
        logic             sync1;
        logic             sync2;
        logic             busy;
    } engine_state_type;

    localparam logic [DIV_W-1:0] HALF_FLOOR = DIV_W'(LAUNCH_DELAY_CYC + 1);

    engine_state_type st_ff;
    engine_state_type nxt_st;
    logic             rise_now;
    logic             fall_now;
    logic             shifting;

    assign shifting = (st_ff.fsm == ST_SHIFT);

    ////////////////////////////////////////////////////////////////////////////
    // tck divider
    jtag_tck_gen #(
        .DIV_W    (DIV_W)
    ) jtag_tck_gen_i (
        .clk      (clk),
        .reset_n  (reset_n),
        .run      (shifting),
        .half     (st_ff.cfg_half),
        .tck      (tck),
        .rise_now (rise_now),
        .fall_now (fall_now)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.cap_valid = 1'b0;
        // tdi comes from another clock domain, so two flops before use
        nxt_st.sync1     = tdi;
        nxt_st.sync2     = st_ff.sync1;
        nxt_st.board_rst_n = ~board_reset_req;

        // settings are staged at once but applied only while idle
        if (cfg_load) begin
            nxt_st.stg_pend     = 1'b1;
            nxt_st.stg_alt      = launch_rise_sel;
            nxt_st.stg_cap_fall = capture_fall_sel;
            // period must leave room for the late launch
            nxt_st.stg_half = (half_period < HALF_FLOOR) ? HALF_FLOOR : half_period;
        end

        // one-entry hold for the next bit
        if (bit_valid && st_ff.bit_ready) begin
            nxt_st.pend     = 1'b1;
            nxt_st.pend_tms = bit_tms;
            nxt_st.pend_tdo = bit_tdo;
        end

        unique case (st_ff.fsm)
            ST_IDLE: begin
                if (st_ff.stg_pend) begin
                    // tck is low and stopped here, so no edge is mixed
                    nxt_st.cfg_alt      = st_ff.stg_alt;
                    nxt_st.cfg_cap_fall = st_ff.stg_cap_fall;
                    nxt_st.cfg_half     = st_ff.stg_half;
                    nxt_st.stg_pend     = cfg_load;
                end else if (st_ff.pend) begin
                    // first bit goes out half a period before the first rise
                    nxt_st.tms      = st_ff.pend_tms;
                    nxt_st.tdo      = st_ff.pend_tdo;
                    nxt_st.pend     = 1'b0;
                    nxt_st.launched = 1'b0;
                    nxt_st.fsm      = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (rise_now) begin
                    nxt_st.launched = 1'b0;
                    nxt_st.dly      = DLY_W'(LAUNCH_DELAY_CYC);
                    if (!st_ff.cfg_cap_fall) begin
                        nxt_st.cap_valid = 1'b1;
                        nxt_st.cap_tdi   = st_ff.sync2;
                    end
                end else if (st_ff.dly != '0) begin
                    nxt_st.dly = st_ff.dly - DLY_W'(1);
                    // late launch, some time after the rise
                    if (st_ff.cfg_alt && st_ff.dly == DLY_W'(1) && st_ff.pend) begin
                        nxt_st.tms      = st_ff.pend_tms;
                        nxt_st.tdo      = st_ff.pend_tdo;
                        nxt_st.pend     = 1'b0;
                        nxt_st.launched = 1'b1;
                    end
                end
                if (fall_now) begin
                    if (st_ff.cfg_cap_fall) begin
                        // target's new bit is still in flight, old one is held
                        nxt_st.cap_valid = 1'b1;
                        nxt_st.cap_tdi   = st_ff.sync2;
                    end
                    if (!st_ff.cfg_alt && st_ff.pend) begin
                        // same clock edge as tck falling, like a ddr pair
                        nxt_st.tms  = st_ff.pend_tms;
                        nxt_st.tdo  = st_ff.pend_tdo;
                        nxt_st.pend = 1'b0;
                    end else if (!(st_ff.cfg_alt && st_ff.launched)) begin
                        nxt_st.fsm = ST_IDLE;
                    end
                end
            end
        endcase
        nxt_st.bit_ready = ~nxt_st.pend;
        // busy leaves from its own flop, matching the shift state it reports
        nxt_st.busy      = (nxt_st.fsm == ST_SHIFT);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; reset settle the defaults of both edge settings
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff              <= '0;
            st_ff.fsm          <= ST_IDLE;
            st_ff.cfg_alt      <= LAUNCH_ALT_RST;
            st_ff.cfg_cap_fall <= CAP_FALL_RST;
            st_ff.cfg_half     <= DIV_W'(HALF_RST);
            st_ff.board_rst_n  <= BOARD_RST_IDLE;
            st_ff.bit_ready    <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tms           = st_ff.tms;
    assign tdo           = st_ff.tdo;
    assign cap_valid     = st_ff.cap_valid;
    assign cap_tdi       = st_ff.cap_tdi;
    assign board_reset_n = st_ff.board_rst_n;
    assign bit_ready     = st_ff.bit_ready;
    assign busy          = st_ff.busy;

    ////////////////////////////////////////////////////////////////////////////
    // checks; helper flops are read only by the assertions
    logic             seen_ff;
    logic             tck_q_ff;
    logic [DIV_W-1:0] hi_cnt_ff;
    logic             tck_rose;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            seen_ff   <= 1'b0;
            tck_q_ff  <= 1'b0;
            hi_cnt_ff <= '0;
        end else begin
            seen_ff   <= 1'b1;
            tck_q_ff  <= tck;
            hi_cnt_ff <= tck ? hi_cnt_ff + DIV_W'(1) : '0;
        end
    end

    assign tck_rose = tck && !tck_q_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    std_launch_edge_a: assert property (
        $past(shifting) && !st_ff.cfg_alt && ($changed(tms) || $changed(tdo))
        |-> $fell(tck)) else $error("standard launch moved pins off the falling edge");
    ddr_align_a: assert property (
        $past(fall_now) && $past(st_ff.pend) && !st_ff.cfg_alt
        |-> !tck && tms == $past(st_ff.pend_tms) && tdo == $past(st_ff.pend_tdo))
        else $error("pins not updated on the tck falling edge");
    alt_launch_delay_a: assert property (
        $past(shifting) && st_ff.cfg_alt && ($changed(tms) || $changed(tdo))
        |-> $past(tck_rose, LAUNCH_DELAY_CYC) && tck)
        else $error("late launch not at the fixed delay after tck rise");
    cap_rise_a: assert property (
        cap_valid && !st_ff.cfg_cap_fall |-> $past(rise_now) && $rose(tck))
        else $error("rising capture not on a tck rise");
    cap_fall_a: assert property (
        cap_valid && st_ff.cfg_cap_fall |-> $past(fall_now) && $fell(tck))
        else $error("falling capture not on a tck fall");
    reset_defaults_a: assert property (
        !seen_ff |-> !st_ff.cfg_alt && st_ff.cfg_cap_fall && !tck)
        else $error("edge settings not at their reset defaults");
    board_reset_a: assert property (
        board_reset_req |=> !board_reset_n ##0 $past(board_reset_req))
        else $error("board reset not driven low on request");
    cfg_idle_a: assert property (
        $changed(st_ff.cfg_alt) || $changed(st_ff.cfg_cap_fall) || $changed(st_ff.cfg_half)
        |-> $past(st_ff.fsm == ST_IDLE) && !tck)
        else $error("edge settings changed while tck running");
    tck_high_len_a: assert property (
        $fell(tck) |-> $past(hi_cnt_ff) == st_ff.cfg_half - DIV_W'(1))
        else $error("tck high phase differs from programmed half period");

    std_bit_c:  cover property (cap_valid && !st_ff.cfg_alt && !st_ff.cfg_cap_fall);
    alt_bit_c:  cover property ($past(shifting) && st_ff.cfg_alt && $changed(tms));
    fall_cap_c: cover property (cap_valid && st_ff.cfg_cap_fall);
    brst_c:     cover property (!board_reset_n);

endmodule
`default_nettype wire

// ---- testbench/jtag_target_model.sv ----
// behavioural target tap: takes tdo in on tck rise, returns it on the following tck fall
`timescale 1ns/1ps
`default_nettype none
module jtag_target_model (
    input  wire logic tck,
    input  wire logic tdo,
    input  wire logic board_reset_n,
    output var  logic tdi
);
    logic held_ff = 1'b0;
    logic tdi_ff  = 1'b0;

    // sample the probe's data on the rising edge; board reset clears the tap
    always @(posedge tck or negedge board_reset_n) begin
        if (!board_reset_n) held_ff <= 1'b0;
        else                held_ff <= tdo;
    end

    // returned data changes only on the falling edge or board reset and is held until the next one
    always @(negedge tck or negedge board_reset_n) begin
        if (!board_reset_n) tdi_ff <= 1'b0;
        else                tdi_ff <= held_ff;
    end

    assign tdi = tdi_ff;
endmodule
`default_nettype wire

// ---- testbench/jtag_edge_engine_tb.sv ----
// self-checking bench for the probe-side jtag edge timing engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module jtag_edge_engine_tb;
    import jtag_edge_pkg::*;
    logic                 clk, reset_n, bit_valid, bit_ready, bit_tms, bit_tdo;
    logic                 cap_valid, cap_tdi, busy, cfg_load, launch_rise_sel;
    logic                 capture_fall_sel, board_reset_req, tck, tms, tdo, tdi;
    logic                 board_reset_n, p_tck, p_tms, p_tdo, p_busy, last_rise;
    logic                 m_alt, m_fall, prev_tdo, ok, e_bit;
    logic [DIV_W_DEF-1:0] half_period;
    logic                 exp_q[$];
    logic [1:0]           pin_q[$];
    logic [1:0]           e_pins;
    int                   fail_count, num_checks, since, hi_cnt, m_h;

    jtag_edge_engine #(.DIV_W(DIV_W_DEF)) jtag_edge_engine_i (
        .clk(clk), .reset_n(reset_n), .bit_valid(bit_valid), .bit_ready(bit_ready),
        .bit_tms(bit_tms), .bit_tdo(bit_tdo), .cap_valid(cap_valid), .cap_tdi(cap_tdi),
        .busy(busy), .cfg_load(cfg_load), .launch_rise_sel(launch_rise_sel),
        .capture_fall_sel(capture_fall_sel), .half_period(half_period),
        .board_reset_req(board_reset_req), .tck(tck), .tms(tms), .tdo(tdo), .tdi(tdi),
        .board_reset_n(board_reset_n));
    jtag_target_model jtag_target_model_i (
        .tck(tck), .tdo(tdo), .board_reset_n(board_reset_n), .tdi(tdi));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // pin monitor: sampled at the falling clk edge, where every output has settled
    always @(negedge clk) begin
        if (reset_n === 1'b1) begin
            since = (tck && !p_tck) ? 0 : since + 1;
            if (tck !== p_tck) last_rise = tck;
            if (tck) hi_cnt++;
            // tms and tdo at the target's sampling edge carry the bit of that period
            if (tck && !p_tck) begin
                e_pins = (pin_q.size() > 0) ? pin_q.pop_front() : ~{tms, tdo};
                `CHK("pins_at_rise", e_pins, {tms, tdo})
            end
            if (!tck && p_tck) begin
                `CHK("tck_high", m_h, hi_cnt)
                hi_cnt = 0;
            end
            // idle start is exempt: pins may move before tck has made any edge
            ok = m_alt ? (tck && since == LAUNCH_DELAY_CYC) : (!tck && p_tck);
            if ((tms !== p_tms || tdo !== p_tdo) && p_busy)
                `CHK("launch_edge", 1'b1, ok)
            if (cap_valid === 1'b1) begin
                `CHK("cap_edge", ~m_fall, last_rise)
                e_bit = (exp_q.size() > 0) ? exp_q.pop_front() : ~cap_tdi;
                `CHK("cap_tdi", e_bit, cap_tdi)
            end
        end
        {p_tck, p_tms, p_tdo, p_busy} = {tck, tms, tdo, busy};
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic timeout();
        fail_count++;
        end_of_test();
    endtask

    // each bit's capture returns the tdo of the bit before it, echoed by the target
    task automatic send(input int n, input logic [15:0] tm, input logic [15:0] td);
        int w;
        for (int i = 0; i < n; i++) begin
            bit_valid = 1'b1;
            bit_tms = tm[i];
            bit_tdo = td[i];
            exp_q.push_back(prev_tdo);
            pin_q.push_back({tm[i], td[i]});
            prev_tdo = td[i];
            w = 0;
            while (bit_ready !== 1'b1 && w < 200) begin
                @(negedge clk);
                w++;
            end
            if (w >= 200) timeout();
            @(negedge clk);
        end
        bit_valid = 1'b0;
    endtask

    task automatic wait_idle();
        int w;
        w = 0;
        repeat (3) @(negedge clk);
        while (busy !== 1'b0 && w < 400) begin
            @(negedge clk);
            w++;
        end
        if (w >= 400) timeout();
        repeat (2) @(negedge clk);
        `CHK("caps_left", 0, exp_q.size())
        `CHK("pins_left", 0, pin_q.size())
    endtask

    task automatic cfg(input logic alt, input logic fall, input int h);
        launch_rise_sel = alt;
        capture_fall_sel = fall;
        half_period = h[DIV_W_DEF-1:0];
        cfg_load = 1'b1;
        @(negedge clk);
        cfg_load = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // reset defaults, then a pause where tck stops and a second burst
    task automatic t_defaults();
        send(6, 16'hB2D4, 16'h4D2B);
        wait_idle();
        send(4, 16'h000A, 16'h0009);
        wait_idle();
    endtask

    // every launch and capture edge pairing; rise capture keeps a longer half period
    task automatic t_modes();
        for (int a = 0; a < 2; a++) begin
            for (int f = 0; f < 2; f++) begin
                cfg(a[0], f[0], 5 - f);
                {m_alt, m_fall, m_h} = {a[0], f[0], 5 - f};
                send(6, 16'h0035, 16'h002D);
                wait_idle();
            end
        end
    endtask

    // settings staged mid-burst must wait until tck is idle
    task automatic t_midcfg();
        cfg(1'b0, 1'b1, 4);
        {m_alt, m_fall, m_h} = {1'b0, 1'b1, 32'h0000_0004};
        send(5, 16'h0016, 16'h0019);
        cfg(1'b1, 1'b1, 4);
        wait_idle();
        m_alt = 1'b1;
        send(4, 16'h0005, 16'h000B);
        wait_idle();
    endtask

    // a half period below the floor is clamped to two clk cycles
    task automatic t_clamp();
        cfg(1'b0, 1'b1, 1);
        {m_alt, m_fall, m_h} = {1'b0, 1'b1, 32'h0000_0002};
        send(5, 16'h0013, 16'h001A);
        wait_idle();
    endtask

    // board reset follows the request one edge later and clears the target
    task automatic t_board();
        board_reset_req = 1'b1;
        @(negedge clk);
        `CHK("board_reset_n", 1'b0, board_reset_n)
        repeat (4) @(negedge clk);
        `CHK("board_reset_n", 1'b0, board_reset_n)
        board_reset_req = 1'b0;
        prev_tdo = 1'b0;
        @(negedge clk);
        `CHK("board_reset_n", 1'b1, board_reset_n)
        send(3, 16'h0002, 16'h0005);
        wait_idle();
    endtask

    initial begin
        {reset_n, bit_valid, bit_tms, bit_tdo, cfg_load, launch_rise_sel} = 6'b0;
        {board_reset_req, prev_tdo, p_tck, p_tms, p_tdo, p_busy, last_rise} = 7'b0;
        capture_fall_sel = 1'b1;
        half_period = 8'h04;
        {m_alt, m_fall, m_h} = {LAUNCH_ALT_RST, CAP_FALL_RST, HALF_RST};
        {fail_count, num_checks, since, hi_cnt} = {32'h0, 32'h0, 32'h0, 32'h0};
        repeat (4) @(negedge clk);
        reset_n = 1'b1;
        @(negedge clk);
        t_defaults();
        t_modes();
        t_midcfg();
        t_clamp();
        t_board();
        end_of_test();
    end
endmodule
`default_nettype wire
